// ---- hw/tvs_pkg.sv ----
// constants of the two-wire register port
// Functional notes
// - device is slave, never drives clock
// - both lines released high when idle
// - drive lines only low or released
// - works up to 400 kbit/s
// - data falls, clock high: START
// - data changes only while clock low
// - data rises, clock high: STOP
// - first byte after START is device select
// - prefix 11101, B2 inverted select, B1 select, B0 direction
// - direction 0 write, 1 read
// - second byte is pointer load, B7 ignored
// - B6 step enable, B5..B0 load pointer
// - accesses go to current pointer
// - step on: pointer advances after write
// - step on: advance before read load, except first
// - step off: pointer fixed after writes
// - step off: pointer fixed on read load
// - always acknowledge written bytes
// - step on: write at pointer 2A: next byte reloads pointer
// - read stepping wraps 2A to 00h
package tvs_pkg;
   localparam logic [4:0] DEV_PREFIX   = 5'h1D;
   localparam logic [5:0] PTR_LAST     = 6'h2A;
   localparam logic [5:0] PTR_RESET    = 6'h00;
   localparam int         STEP_BIT     = 6;
   localparam int         BIT_RATE_KBPS = 400;
   localparam int         CLK_MHZ      = 250;
   // shortest clock-high phase at full rate, in system cycles (0.6 us)
   localparam int         HIGH_NS      = 600;
   localparam int         HIGH_CYC     = (HIGH_NS * CLK_MHZ) / 1000;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_DEV  = 6'b000010,
      ST_PTR  = 6'b000100,
      ST_WDAT = 6'b001000,
      ST_RDAT = 6'b010000,
      ST_ACK  = 6'b100000
   } tvs_state_t;
endpackage

// ---- hw/tvs_serial_port.sv ----
// two-wire slave port that steers the register pointer and strobes
`timescale 1ns/1ns
`default_nettype none
module tvs_serial_port
   import tvs_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       serial_clock_line_i,
   input  wire logic       serial_data_line_i,
   output logic            serial_data_line_o,
   output logic            serial_data_line_oe_o,
   input  wire logic       addr_select_i,
   input  wire logic [7:0] reg_rdata_i,
   output logic [5:0]      register_pointer_field_o,
   output logic            pointer_step_enable_o,
   output logic            reg_write_o,
   output logic [7:0]      reg_wdata_o,
   output logic            reg_read_o,
   output logic            busy_o
);
   // inputs are synchronous; one stage gives the previous line levels
   logic       scl_q;
   logic       sda_q;
   logic       start_ev;
   logic       stop_ev;
   logic       frame_ev;
   logic       scl_rise;
   logic       scl_fall;
   logic       in_byte;
   logic       byte_done;
   logic       dev_match;
   logic       ack_enter;
   logic       ack_leave;
   logic       load_read;
   tvs_state_t state_q;
   tvs_state_t after_ack_q;
   logic [2:0] bit_q;
   logic [7:0] shift_q;
   logic [7:0] byte_in;
   logic [5:0] ptr_q;
   logic       step_q;
   logic       first_rd_q;
   logic       wrap_load_q;
   logic       rd_q;
   logic       ack_mine_q;
   logic       ack_phase_q;
   logic       nack_q;
   logic       wr_q;
   logic       rdstb_q;
   logic [7:0] wdata_q;
   logic [7:0] hold_q;
   logic       drive_low_q;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= serial_clock_line_i;
         sda_q <= serial_data_line_i;
      end
   end

   assign start_ev = scl_q && serial_clock_line_i && sda_q && !serial_data_line_i;
   assign stop_ev  = scl_q && serial_clock_line_i && !sda_q && serial_data_line_i;
   assign frame_ev = start_ev || stop_ev;
   assign scl_rise = !scl_q && serial_clock_line_i;
   assign scl_fall = scl_q && !serial_clock_line_i;
   assign byte_in  = {shift_q[6:0], serial_data_line_i};
   assign in_byte  = (state_q == ST_DEV) || (state_q == ST_PTR)
                     || (state_q == ST_WDAT) || (state_q == ST_RDAT);
   // eighth bit of a byte is sampled on this edge
   assign byte_done = !frame_ev && in_byte && scl_rise && (bit_q == 3'h7);
   // prefix, inverted select, select, then direction
   assign dev_match = (byte_in[7:1] == {DEV_PREFIX, ~addr_select_i, addr_select_i});
   // ninth clock: its leading fall opens the phase, the next fall closes it
   assign ack_enter = !frame_ev && (state_q == ST_ACK) && scl_fall && !ack_phase_q;
   assign ack_leave = !frame_ev && (state_q == ST_ACK) && scl_fall && ack_phase_q;
   // a read byte is loaded once the ninth clock closes without a master nack
   assign load_read = ack_leave && (after_ack_q == ST_RDAT) && (ack_mine_q || !nack_q);

   // protocol sequencer
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_IDLE;
      end else if (start_ev) begin
         state_q <= ST_DEV;
      end else if (stop_ev) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_q <= ST_IDLE;
            end
            ST_DEV: begin
               if (byte_done) begin
                  if (dev_match) begin
                     state_q <= ST_ACK;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
            ST_PTR, ST_WDAT, ST_RDAT: begin
               if (byte_done) begin
                  state_q <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (ack_leave) begin
                  // a master nack ends read output until the next start
                  if (!ack_mine_q && nack_q) begin
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= after_ack_q;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // where the sequencer goes once the ninth clock is over
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         after_ack_q <= ST_IDLE;
      end else if (byte_done) begin
         case (state_q)
            ST_DEV: begin
               after_ack_q <= byte_in[0] ? ST_RDAT : ST_PTR;
            end
            ST_RDAT: begin
               after_ack_q <= ST_RDAT;
            end
            default: begin
               after_ack_q <= ST_WDAT;
            end
         endcase
      end
   end

   // direction of the transfer in progress
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_q <= 1'b0;
      end else if (byte_done && (state_q == ST_DEV) && dev_match) begin
         rd_q <= byte_in[0];
      end
   end

   // the port answers the ninth clock for every byte the master sent, except a device select for another address
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_mine_q <= 1'b0;
      end else if (byte_done) begin
         ack_mine_q <= (state_q != ST_RDAT);
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_phase_q <= 1'b0;
      end else if (frame_ev) begin
         ack_phase_q <= 1'b0;
      end else if (ack_enter) begin
         ack_phase_q <= 1'b1;
      end else if (ack_leave) begin
         ack_phase_q <= 1'b0;
      end
   end

   // master answer to a read byte, sampled on the ninth rise
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         nack_q <= 1'b0;
      end else if (start_ev) begin
         nack_q <= 1'b0;
      end else if (!stop_ev && (state_q == ST_ACK) && ack_phase_q && scl_rise) begin
         nack_q <= serial_data_line_i;
      end
   end

   // bit counter within a byte
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bit_q <= 3'h0;
      end else if (start_ev) begin
         bit_q <= 3'h0;
      end else if (!stop_ev && in_byte && scl_rise) begin
         bit_q <= bit_q + 3'h1;
      end else if (ack_leave) begin
         bit_q <= 3'h0;
      end
   end

   // incoming bits, most significant first
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         shift_q <= 8'h00;
      end else if (!frame_ev && in_byte && scl_rise) begin
         shift_q <= byte_in;
      end
   end

   // pointer and step mode
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ptr_q       <= PTR_RESET;
         step_q      <= 1'b0;
         first_rd_q  <= 1'b1;
         wrap_load_q <= 1'b0;
      end else if (byte_done && (state_q == ST_PTR)) begin
         // bit 7 not looked at
         ptr_q       <= byte_in[5:0];
         step_q      <= byte_in[STEP_BIT];
         first_rd_q  <= 1'b1;
         wrap_load_q <= 1'b0;
      end else if (byte_done && (state_q == ST_WDAT) && wrap_load_q) begin
         ptr_q       <= byte_in[5:0];
         wrap_load_q <= 1'b0;
      end else if (byte_done && (state_q == ST_WDAT)) begin
         if (step_q) begin
            if (ptr_q == PTR_LAST) begin
               wrap_load_q <= 1'b1;
            end else begin
               ptr_q <= ptr_q + 6'h01;
            end
         end // pointer kept
      end else if (load_read) begin
         if (step_q && !first_rd_q) begin
            ptr_q <= (ptr_q == PTR_LAST) ? PTR_RESET : ptr_q + 6'h01;
         end // pointer kept when step off
         first_rd_q <= 1'b0;
      end
   end

   // write strobe; the pointer steps on the same edge
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_q    <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         wr_q <= byte_done && (state_q == ST_WDAT) && !wrap_load_q;
         if (byte_done && (state_q == ST_WDAT) && !wrap_load_q) begin
            wdata_q <= byte_in;
         end
      end
   end

   // read strobe; register data is taken one cycle later
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdstb_q <= 1'b0;
      end else begin
         rdstb_q <= load_read;
      end
   end

   // read holding register
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         hold_q <= 8'hFF;
      end else if (rdstb_q) begin
         hold_q <= reg_rdata_i;
      end else if ((state_q == ST_RDAT) && scl_fall) begin
         hold_q <= {hold_q[6:0], 1'b1};
      end
   end

   // open-drain data drive; it only moves while the clock is low
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         drive_low_q <= 1'b0;
      end else if (frame_ev) begin
         drive_low_q <= 1'b0;
      end else if (state_q == ST_RDAT) begin
         drive_low_q <= ~hold_q[7];
      end else if ((state_q == ST_ACK) && !ack_phase_q && !ack_mine_q) begin
         // last read bit stays until its clock falls
         drive_low_q <= drive_low_q;
      end else if ((state_q == ST_ACK) && ack_phase_q && ack_mine_q) begin
         drive_low_q <= 1'b1;
      end else begin
         drive_low_q <= 1'b0;
      end
   end

   // data line only pulled low or released; clock line never driven
   assign serial_data_line_o       = 1'b0;
   assign serial_data_line_oe_o    = drive_low_q;
   assign register_pointer_field_o = ptr_q;
   assign pointer_step_enable_o    = step_q;
   assign reg_write_o              = wr_q;
   assign reg_wdata_o              = wdata_q;
   assign reg_read_o               = rdstb_q;
   assign busy_o                   = (state_q != ST_IDLE);
   // at 250 MHz a 400 kbit/s bit holds many cycles, so edge sampling is safe
endmodule
`default_nettype wire

// ---- testbench/tvs_port_asserts.sv ----
// assertions on the two-wire register port
`timescale 1ns/1ns
`default_nettype none
module tvs_port_asserts
   import tvs_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       reset_n_i,
   input wire logic       serial_clock_line_i,
   input wire logic       serial_data_line_i,
   input wire logic       serial_data_line_o,
   input wire logic       serial_data_line_oe_o,
   input wire logic [5:0] register_pointer_field_o,
   input wire logic       pointer_step_enable_o,
   input wire logic       reg_write_o,
   input wire logic       reg_read_o,
   input wire logic       busy_o
);
   wire logic       scl = serial_clock_line_i;
   wire logic       sda = serial_data_line_i;
   wire logic       oe  = serial_data_line_oe_o;
   wire logic [5:0] p   = register_pointer_field_o;
   wire logic       st  = pointer_step_enable_o;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   idle_release_a: assert property (!busy_o |-> !oe)
      else $error("data pulled while idle");
   start_busy_a: assert property (scl && $past(scl) && $fell(sda) |-> ##[0:4] busy_o)
      else $error("start not taken");
   stop_idle_a: assert property (scl && $past(scl) && $rose(sda) |-> ##[1:6] !busy_o)
      else $error("stop not taken");
   ack_steady_a: assert property (scl && $past(scl) |-> $stable(oe))
      else $error("data moved while clock high");
   drive_low_a: assert property (serial_data_line_o == 1'b0)
      else $error("data driven high");
   write_step_a: assert property (reg_write_o && st && $past(p) != PTR_LAST |-> p == $past(p) + 6'h01)
      else $error("pointer not stepped after write");
   write_hold_a: assert property (reg_write_o && !st |-> $stable(p))
      else $error("pointer moved after write");
   read_hold_a: assert property (reg_read_o && !st |-> $stable(p))
      else $error("pointer moved on read load");
   strobe_busy_a: assert property (reg_write_o || reg_read_o |-> busy_o && !(reg_write_o && reg_read_o))
      else $error("strobe outside transfer");
   cover property (reg_write_o && st);
   cover property (reg_read_o && st);
   cover property (reg_read_o && !st);
endmodule
bind tvs_serial_port tvs_port_asserts chk_u (.clk_i, .reset_n_i, .serial_clock_line_i,
   .serial_data_line_i, .serial_data_line_o, .serial_data_line_oe_o, .register_pointer_field_o,
   .pointer_step_enable_o, .reg_write_o, .reg_read_o, .busy_o);
`default_nettype wire

// ---- testbench/tvs_bus_master.sv ----
// two-wire bus master that clocks the port
`timescale 1ns/1ns
`default_nettype none
module tvs_bus_master (
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   localparam int Q = 80;
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wt();
      repeat (Q) @(posedge clk_i);
      #1;
   endtask
   // one clock pulse; only the master moves the clock, which it drives high and low; data line only low or released
   // bits set with clock low, start/stop by changing data mid-high
   task automatic phase(input logic s1, input logic s2, input logic c2, output logic r);
      sda_low_o = s1;
      wt();
      scl_o = 1'b1;
      wt();
      r = sda_i;
      sda_low_o = s2;
      wt();
      scl_o = c2;
      wt();
   endtask
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         phase(!tx[i], !tx[i], 1'b0, rx[i]);
      end
   endtask
endmodule
`default_nettype wire

// ---- testbench/tvs_serial_port_bench.sv ----
// self-checking bench for the two-wire register port
`timescale 1ns/1ns
`default_nettype none
module tvs_serial_port_bench
   import tvs_pkg::*;
;
   logic       clk_i, reset_n_i, sel, oe, o, wr, rd, st, busy, r;
   logic [7:0] rdata, wdata, mem[64], expm[64];
   logic [5:0] ptr, ptr_prev;
   logic [8:0] rx;
   wire logic  scl, sda_low;
   wire logic  sda = !(sda_low || (oe && !o));
   int         fails = 0, num_checks = 0;
   tvs_serial_port dut_u (.clk_i, .reset_n_i, .serial_clock_line_i(scl),
      .serial_data_line_i(sda), .serial_data_line_o(o), .serial_data_line_oe_o(oe),
      .addr_select_i(sel), .reg_rdata_i(rdata), .register_pointer_field_o(ptr),
      .pointer_step_enable_o(st), .reg_write_o(wr), .reg_wdata_o(wdata), .reg_read_o(rd),
      .busy_o(busy));
   tvs_bus_master m_u (.clk_i, .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   assign rdata = mem[ptr];
   // the pointer steps with the strobe, so the write goes where it pointed before
   always @(posedge clk_i) begin
      ptr_prev <= ptr;
      if (wr) begin
         mem[ptr_prev] <= wdata;
      end
   end
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = !clk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] d);
      m_u.xfer({d, 1'b1}, rx);
      chk({7'h00, rx[0]}, 8'h00);
   endtask
   task automatic put(input logic [7:0] d, input logic [5:0] a);
      send(d);
      expm[a] = d;
   endtask
   task automatic setp(input logic s, input logic [5:0] a);
      m_u.phase(1'b0, 1'b1, 1'b0, r);
      send({DEV_PREFIX, !sel, sel, 1'b0});
      send({1'($urandom), s, a});
   endtask
   task automatic rdsel();
      m_u.phase(1'b0, 1'b1, 1'b0, r);
      send({DEV_PREFIX, !sel, sel, 1'b1});
   endtask
   task automatic get(input logic last, input logic [5:0] a);
      m_u.xfer({8'hFF, last}, rx);
      chk(rx[8:1], expm[a]);
   endtask
   task automatic stop();
      m_u.phase(1'b1, 1'b0, 1'b1, r);
   endtask
   initial begin
      repeat (100000) @(posedge clk_i);
      fails++;
      print_verdict();
   end
   initial begin
      logic [5:0] a;
      reset_n_i = 1'b0;
      void'($urandom(32'h42C6B77A));
      for (int i = 0; i < 64; i++) begin
         mem[i] = 8'($urandom);
         expm[i] = mem[i];
      end
      sel = 1'($urandom);
      repeat (6) @(posedge clk_i);
      #1 reset_n_i = 1'b1;
      repeat (2) @(posedge clk_i);
      chk({1'b0, st, ptr}, 8'h00);
      // foreign address left unanswered
      m_u.phase(1'b0, 1'b1, 1'b0, r);
      m_u.xfer({DEV_PREFIX, sel, !sel, 1'b0, 1'b1}, rx);
      chk({7'h00, rx[0]}, 8'h01);
      stop();
      // fixed pointer: both bytes land in one register
      a = 6'($urandom_range(40));
      setp(1'b0, a);
      put(8'($urandom), a);
      put(8'($urandom), a);
      stop();
      chk({2'b00, ptr}, {2'b00, a});
      // stepping writes across the last register, then a pointer reload byte to 05
      setp(1'b1, 6'h29);
      put(8'($urandom), 6'h29);
      put(8'($urandom), PTR_LAST);
      send(8'h45);
      put(8'($urandom), 6'h05);
      put(8'($urandom), 6'h06);
      stop();
      chk({2'b00, ptr}, 8'h07);
      for (int i = 0; i < 64; i++) begin
         chk(mem[i], expm[i]);
      end
      // stepping reads wrap to zero
      setp(1'b1, 6'h29);
      rdsel();
      get(1'b0, 6'h29);
      get(1'b0, PTR_LAST);
      get(1'b1, PTR_RESET);
      stop();
      // fixed pointer reads, other strap value
      sel = !sel;
      a = 6'($urandom_range(63));
      setp(1'b0, a);
      rdsel();
      get(1'b0, a);
      get(1'b1, a);
      stop();
      chk({2'b00, ptr}, {2'b00, a});
      print_verdict();
   end
endmodule
`default_nettype wire
